// ==== hw/adc_ctl_pkg.sv ====
package adc_ctl_pkg;

  // Clock rates, in kHz as printed
  localparam int unsigned CLK_FREQ_KHZ = 125000;
  localparam int unsigned RC_FREQ_KHZ = 1500;
  // RC conversion clock as a tick every RC_DIV bus cycles (rounded down)
  localparam logic [6:0] RC_DIV = 7'(CLK_FREQ_KHZ / RC_FREQ_KHZ);

  // Conversion timing: sampling in bus cycles, the rest in conversion clock cycles
  localparam logic [5:0] CONV_CYCLES = 6'h20;
  localparam logic [4:0] SAMPLE_CYCLES = 5'hc;
  localparam logic [4:0] CONVERT_LAST = 5'(CONV_CYCLES - 6'(SAMPLE_CYCLES) - 6'h1);
  localparam logic [4:0] SAR_BITS = 5'h8;
  localparam logic [7:0] SAR_FIRST = 8'h80;

  // Register indices and byte addresses (byte address = index * 4)
  localparam logic [5:0] RESULT_IDX = 6'h10;
  localparam logic [5:0] STATUS_IDX = 6'h11;
  localparam logic [7:0] ADDR_RESULT = {RESULT_IDX, 2'h0};
  localparam logic [7:0] ADDR_STATUS = {STATUS_IDX, 2'h0};

  // Status/control field positions
  localparam int unsigned DONE_BIT = 7;
  localparam int unsigned RC_BIT = 6;
  localparam int unsigned ON_BIT = 5;
  localparam int unsigned CH_LSB = 0;
  localparam int unsigned CH_W = 3;

  // Reset values
  localparam logic [7:0] RESULT_RST = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CH_PIN0 = 3'h0,
    CH_PIN1 = 3'h1,
    CH_PIN2 = 3'h2,
    CH_PIN3 = 3'h3,
    CH_REF_HIGH = 3'h4,
    CH_REF_MID = 3'h5,
    CH_REF_LOW = 3'h6,
    CH_TEST = 3'h7
  } chan_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_CONVERT = 3'h4
  } conv_state_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } div_state_t;

  typedef struct packed {
    logic [7:0] trial;
    logic [7:0] mask;
  } sar_state_t;

  typedef struct packed {
    conv_state_t st;
    logic [4:0] cnt;
    logic done;
    logic rc_sel;
    logic pwr;
    chan_t ch;
    logic [7:0] result;
    logic sample_sw;
    logic pump_on;
    logic osc_on;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ctl_state_t;

endpackage : adc_ctl_pkg

// ==== hw/rc_tick_divider.sv ====
`timescale 1ns/1ps
// Stands in for the RC oscillator: one-cycle tick every RC_DIV cycles
module rc_tick_divider (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  // Tick out
  output logic tick
);

  adc_ctl_pkg::div_state_t q;
  adc_ctl_pkg::div_state_t n;

  // Count restarts whenever the oscillator is off, so the first tick is late
  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 7'h0;
    end else if (q.cnt == adc_ctl_pkg::RC_DIV - 7'h1) begin
      n.cnt = 7'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 7'h1;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick;

endmodule : rc_tick_divider

// ==== hw/sar_engine.sv ====
`timescale 1ns/1ps
// Successive approximation: one bit decided per step, MSB first
module sar_engine (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sequencing
  input wire logic start,
  input wire logic step,
  // Analog side
  input wire logic comparator_above,
  output logic [7:0] trial
);

  adc_ctl_pkg::sar_state_t q;
  adc_ctl_pkg::sar_state_t n;

  // Drop the bit under test if the input is below the trial level
  always_comb begin
    n = q;
    if (start) begin
      n.trial = adc_ctl_pkg::SAR_FIRST;
      n.mask = adc_ctl_pkg::SAR_FIRST;
    end else if (step && (q.mask != 8'h00)) begin
      n.mask = q.mask >> 1;
      n.trial = (comparator_above ? q.trial : (q.trial & ~q.mask)) | n.mask;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign trial = q.trial;

endmodule : sar_engine

// ==== hw/adc_channel_control.sv ====
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Contract
// - RC pace, results enter on bus clock
// - Power bit switches converter on/off
// - Reset clears converter power bit
// - Three-bit field selects pins or references
// - Read-only 8-bit result at 0x10
// - Result load and done flag together
// - Conversion continues during WAIT
// - STOP halts converter, aborts conversion
// - Sample switch closed 12 bus cycles
// - Input disconnected during hold phase
// - Conversion takes 32 conversion clocks; in RC mode the code takes 12 bus cycles plus 20 RC ticks
// - Continuous conversions, flag after each
// - Done clears on result read, status write
// - RC select runs oscillator, clocks converter
module adc_channel_control (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // System mode
  input wire logic stop_mode,
  // Analog side
  input wire logic comparator_above,
  output logic [2:0] channel_select,
  output logic sample_switch,
  output logic converter_power,
  output logic rc_osc_on,
  output logic [7:0] dac_code
);

  adc_ctl_pkg::ctl_state_t q;
  adc_ctl_pkg::ctl_state_t n;
  logic rc_tick;
  logic conv_tick;
  logic start_sar;
  logic step_sar;
  logic done_set;
  logic rd_result;
  logic st_write;
  logic ch_change;
  logic halt;
  logic [7:0] sar_trial;
  adc_ctl_pkg::chan_t new_ch;

  // RC oscillator runs while selected and not stopped
  rc_tick_divider u_rc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(q.osc_on),
    .tick(rc_tick)
  );

  sar_engine u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_sar),
    .step(step_sar),
    .comparator_above(comparator_above),
    .trial(sar_trial)
  );

  // Bus clock converts every cycle; RC mode only on oscillator ticks
  assign conv_tick = q.rc_sel ? rc_tick : 1'b1;
  assign new_ch = adc_ctl_pkg::chan_t'(q.w_data[adc_ctl_pkg::CH_LSB +:
                                                 adc_ctl_pkg::CH_W]);

  // Bus slave, control register, converter sequencing
  always_comb begin
    n = q;
    start_sar = 1'b0;
    step_sar = 1'b0;
    done_set = 1'b0;
    rd_result = 1'b0;
    st_write = 1'b0;
    ch_change = 1'b0;
    // Address and data may arrive in either order
    if (awvalid && q.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_held = 1'b1;
      n.w_data = wdata[7:0];
      n.w_lane0 = wstrb[0];
    end
    if (bready && q.bvalid) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = adc_ctl_pkg::RESP_OKAY;
      if (q.aw_addr == adc_ctl_pkg::ADDR_STATUS) begin
        st_write = 1'b1;
        if (q.w_lane0) begin
          n.rc_sel = q.w_data[adc_ctl_pkg::RC_BIT];
          n.pwr = q.w_data[adc_ctl_pkg::ON_BIT];
          n.ch = new_ch;
          ch_change = (new_ch != q.ch);
        end
      end else begin
        // Result register is read-only; other addresses unmapped
        n.bresp = adc_ctl_pkg::RESP_SLVERR;
      end
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;
    // Read side answers one cycle after the address is taken
    if (rready && q.rvalid) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = adc_ctl_pkg::RESP_OKAY;
      n.rdata = 8'h00;
      if (araddr == adc_ctl_pkg::ADDR_RESULT) begin
        n.rdata = q.result;
        rd_result = 1'b1;
      end else if (araddr == adc_ctl_pkg::ADDR_STATUS) begin
        n.rdata = {q.done, q.rc_sel, q.pwr, 2'h0, q.ch};
      end else begin
        n.rresp = adc_ctl_pkg::RESP_SLVERR;
      end
    end
    n.arready = !n.rvalid;
    // Converter sequence; WAIT has no input here, so it never pauses
    case (q.st)
      adc_ctl_pkg::ST_OFF: begin
        n.st = adc_ctl_pkg::ST_SAMPLE;
        n.cnt = 5'h0;
        n.sample_sw = 1'b1;
        start_sar = 1'b1;
      end
      adc_ctl_pkg::ST_SAMPLE: begin
        if (q.cnt == adc_ctl_pkg::SAMPLE_CYCLES - 5'h1) begin
          n.st = adc_ctl_pkg::ST_CONVERT;
          n.cnt = 5'h0;
          n.sample_sw = 1'b0;
        end else begin
          n.cnt = q.cnt + 5'h1;
        end
      end
      adc_ctl_pkg::ST_CONVERT: begin
        if (conv_tick) begin
          step_sar = (q.cnt < adc_ctl_pkg::SAR_BITS);
          if (q.cnt == adc_ctl_pkg::CONVERT_LAST) begin
            // Result and flag land together, in the same cycle as the next run starts
            done_set = 1'b1;
            n.result = sar_trial;
            n.st = adc_ctl_pkg::ST_SAMPLE;
            n.cnt = 5'h0;
            n.sample_sw = 1'b1;
            start_sar = 1'b1;
          end else begin
            n.cnt = q.cnt + 5'h1;
          end
        end
      end
      default: begin
        n.st = adc_ctl_pkg::ST_OFF;
      end
    endcase
    // STOP or power off drops the conversion in progress and keeps the old result
    halt = stop_mode || !n.pwr;
    if (halt) begin
      n.st = adc_ctl_pkg::ST_OFF;
      n.cnt = 5'h0;
      n.sample_sw = 1'b0;
      n.result = q.result;
      start_sar = 1'b0;
      step_sar = 1'b0;
      done_set = 1'b0;
    end else if (ch_change) begin
      // Half-finished result belongs to the old channel, so drop it
      n.st = adc_ctl_pkg::ST_SAMPLE;
      n.cnt = 5'h0;
      n.sample_sw = 1'b1;
      n.result = q.result;
      start_sar = 1'b1;
      step_sar = 1'b0;
      done_set = 1'b0;
    end
    // Set beats clear when both land in one cycle
    if (rd_result || st_write) begin
      n.done = 1'b0;
    end
    if (done_set) begin
      n.done = 1'b1;
    end
    n.pump_on = n.pwr && !stop_mode;
    n.osc_on = n.rc_sel && !stop_mode;
  end

  // State register; power and RC select come up cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= adc_ctl_pkg::ST_OFF;
      q.result <= adc_ctl_pkg::RESULT_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = {24'h00_0000, q.rdata};
  assign rresp = q.rresp;
  assign channel_select = q.ch;
  assign sample_switch = q.sample_sw;
  assign converter_power = q.pump_on;
  assign rc_osc_on = q.osc_on;
  assign dac_code = sar_trial;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_power_off: assert property (
    $rose(aresetn) |-> !q.pwr && !q.done && q.st == adc_ctl_pkg::ST_OFF)
    else $error("converter not off after reset");

  a_sample_twelve: assert property (
    $fell(q.sample_sw) && q.st == adc_ctl_pkg::ST_CONVERT
    |-> $past(q.sample_sw, 12) && $past(q.st, 12) == adc_ctl_pkg::ST_SAMPLE)
    else $error("sample window not twelve cycles");

  a_hold_isolated: assert property (
    q.st != adc_ctl_pkg::ST_SAMPLE |-> !q.sample_sw)
    else $error("input connected outside sample window");

  a_result_with_flag: assert property (
    $rose(q.done) |-> q.result == $past(sar_trial) && $changed(q.st))
    else $error("done flag without result load");

  a_stop_aborts: assert property (
    stop_mode |=> q.st == adc_ctl_pkg::ST_OFF && !q.pump_on && !q.osc_on
    && !q.sample_sw && (!q.done || $past(q.done)))
    else $error("conversion continued in stop");

  a_read_clears_done: assert property (
    arvalid && arready && araddr == adc_ctl_pkg::ADDR_RESULT && !done_set
    |=> !q.done)
    else $error("done flag survived result read");

  a_bus_conv_end: assert property (
    q.st == adc_ctl_pkg::ST_CONVERT && !q.rc_sel && !halt && !ch_change
    && q.cnt == adc_ctl_pkg::CONVERT_LAST
    |=> q.done && q.st == adc_ctl_pkg::ST_SAMPLE && q.sample_sw)
    else $error("conversion did not end on its last cycle");

  a_rc_paced: assert property (
    q.st == adc_ctl_pkg::ST_CONVERT && q.rc_sel && !rc_tick && !halt
    && !ch_change |=> $stable(q.cnt) && $stable(q.result))
    else $error("conversion advanced without rc tick");

  a_chan_restart: assert property (
    ch_change && !halt |=> q.st == adc_ctl_pkg::ST_SAMPLE
    && q.cnt == 5'h0 && q.sample_sw ##1 sar_trial == adc_ctl_pkg::SAR_FIRST)
    else $error("channel change did not restart sampling");

  a_power_off_idle: assert property (
    !q.pwr |-> q.st == adc_ctl_pkg::ST_OFF && !q.pump_on)
    else $error("converter active while disabled");

endmodule : adc_channel_control

// ==== sim/analog_front_model.sv ====
`timescale 1ns/1ps
// Input selector, hold capacitor and comparator in front of the converter
module analog_front_model (
  // Clock
  input wire logic aclk,
  // Converter side
  input wire logic [2:0] channel_select,
  input wire logic sample_switch,
  input wire logic converter_power,
  input wire logic [7:0] dac_code,
  // Levels of the four analog pins, pin 0 in the low byte
  input wire logic [31:0] pin_levels,
  output logic comparator_above
);
  logic [7:0] level;
  logic [7:0] held;
  logic flip = 1'b0;

  // Pins, then high reference, midpoint and low reference
  always_comb begin
    case (channel_select)
      3'h4: level = 8'hff;
      3'h5: level = 8'h80;
      3'h6: level = 8'h00;
      3'h7: level = 8'h5a; // Test input, arbitrary value
      default: level = pin_levels[{channel_select[1:0], 3'h0} +: 8];
    endcase
  end

  // Capacitor tracks only while the switch is closed, then holds
  always @(posedge aclk) begin
    if (sample_switch) held <= level;
    flip <= ~flip;
  end

  // Unpowered comparator wanders, so a dead converter cannot pass
  assign comparator_above = converter_power ? (held >= dac_code) : flip;
endmodule : analog_front_model

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, stop_mode, comparator_above;
  logic sample_switch, converter_power, rc_osc_on;
  logic [7:0] awaddr, araddr, dac_code, last;
  logic [31:0] wdata, rdata, seed, pins, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] channel_select;
  logic chk = 1'b0;
  logic armed = 1'b0;
  logic sw_d = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int rise_t = 0;

  adc_channel_control dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .stop_mode(stop_mode), .comparator_above(comparator_above),
    .channel_select(channel_select), .sample_switch(sample_switch),
    .converter_power(converter_power), .rc_osc_on(rc_osc_on),
    .dac_code(dac_code)
  );

  analog_front_model afe (
    .aclk(aclk), .channel_select(channel_select),
    .sample_switch(sample_switch), .converter_power(converter_power),
    .dac_code(dac_code), .pin_levels(pins),
    .comparator_above(comparator_above)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction : lfsr

  // Code the converter should return for channels 0 to 6 and pin levels
  function automatic logic [7:0] expect_code(input logic [2:0] c,
      input logic [31:0] p);
    case (c)
      3'h4: return 8'hff;
      3'h5: return 8'h80;
      3'h6: return 8'h00;
      default: return p[{c[1:0], 3'h0} +: 8];
    endcase
  endfunction : expect_code

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic results;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h00_0000, v};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : rd

  // Polling is the only safe wait: RC timing drifts
  task automatic wait_done;
    do rd(adc_ctl_pkg::ADDR_STATUS); while (d[7] !== 1'b1);
  endtask : wait_done

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Hang guard
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    results();
  end

  // Sample window and conversion period, armed only in steady runs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    sw_d <= sample_switch;
    if (sample_switch && !sw_d) begin
      if (armed && chk) cmp(cyc - rise_t, 32);
      rise_t <= cyc;
      armed <= chk;
    end
    if (!chk) armed <= 1'b0;
    if (!sample_switch && sw_d && armed && chk) cmp(cyc - rise_t, 12);
  end

  initial begin
    aresetn <= 1'b0;
    {awvalid, wvalid, arvalid, stop_mode} <= 4'h0;
    {bready, rready} <= 2'h3;
    {awaddr, araddr} <= 16'h0000;
    wdata <= 32'h0000_0000;
    wstrb <= 4'h1;
    seed = 32'he68b_8a74;
    pins <= seed;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(adc_ctl_pkg::ADDR_STATUS);
    cmp(d, 32'h0000_0000);
    cmp(converter_power, 0);
    cmp(dac_code, 8'h00);
    wr(adc_ctl_pkg::ADDR_RESULT, 8'haa);
    cmp(r, adc_ctl_pkg::RESP_SLVERR);
    rd(8'h48);
    cmp(r, adc_ctl_pkg::RESP_SLVERR);
    // Channel codes 0 to 6; each write after the first also restarts a running conversion
    for (int c = 0; c < 7; c++) begin
      seed = lfsr(seed);
      pins <= seed;
      chk <= 1'b0;
      wr(adc_ctl_pkg::ADDR_STATUS, {5'h04, c[2:0]});
      cmp(r, adc_ctl_pkg::RESP_OKAY);
      chk <= 1'b1;
      // First result after power-up may be off while sources settle
      if (c == 0) begin
        wait_done;
        rd(adc_ctl_pkg::ADDR_RESULT);
      end
      wait_done;
      rd(adc_ctl_pkg::ADDR_RESULT);
      cmp(d, expect_code(c[2:0], seed));
      rd(adc_ctl_pkg::ADDR_STATUS);
      cmp(d, {24'h00_0000, 5'h04, c[2:0]});
      cmp(channel_select, c);
      cmp(converter_power, 1);
      repeat (70) @(posedge aclk);
    end
    chk <= 1'b0;
    wait_done;
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h26);
    rd(adc_ctl_pkg::ADDR_STATUS);
    cmp(d[7], 0);
    // RC conversion clock
    seed = lfsr(seed);
    pins <= seed;
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h62);
    @(posedge aclk);
    cmp(rc_osc_on, 1);
    wait_done;
    rd(adc_ctl_pkg::ADDR_RESULT);
    cmp(d, expect_code(3'h2, seed));
    last = d[7:0];
    // STOP in mid-conversion gives no result and keeps the old one
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h21);
    repeat (20) @(posedge aclk);
    stop_mode <= 1'b1;
    repeat (60) @(posedge aclk);
    cmp(converter_power, 0);
    cmp(sample_switch, 0);
    rd(adc_ctl_pkg::ADDR_STATUS);
    cmp(d[7], 0);
    rd(adc_ctl_pkg::ADDR_RESULT);
    cmp(d, {24'h00_0000, last});
    stop_mode <= 1'b0;
    wait_done;
    rd(adc_ctl_pkg::ADDR_RESULT);
    cmp(d, expect_code(3'h1, seed));
    // Power off: no further completions
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h01);
    @(posedge aclk);
    cmp(converter_power, 0);
    cmp(rc_osc_on, 0);
    repeat (40) @(posedge aclk);
    rd(adc_ctl_pkg::ADDR_STATUS);
    cmp(d, 32'h0000_0001);
    results();
  end
endmodule : tb_top
